//--- verilog/int_vector_map.sv
// Per-core interrupt vector map: source routing, levels and vector address

module int_vector_map (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rstn,
	// Core identity and setup
	input wire logic core_id,
	input wire logic [vector_map_pkg::ADDR_W-1:0] vector_base,
	input wire logic [1:0] interrupt_priority_level,
	input wire logic [2*vector_map_pkg::SLOTS-1:0] slot_levels,
	// Core exceptions and shared external requests
	input wire logic reset_req,
	input wire logic stack_error,
	input wire logic illegal_instr,
	input wire logic debug_req,
	input wire logic trap_req,
	input wire logic ext_nmi,
	input wire logic ext_request_a,
	input wire logic ext_request_b,
	input wire logic ext_request_c,
	input wire logic ext_request_d,
	// Stall from both monitor instances
	input wire logic core_interface_monitor,
	input wire logic core_interface_monitor_second,
	// DMA channels from both instances
	input wire logic [7:0] dma_first,
	input wire logic [7:0] dma_second,
	// Inter-core channel from the other core
	input wire logic icc_nmi,
	input wire logic icc_request,
	input wire logic icc_ack,
	// Serial audio: [3:0] rx data, even, exception, last; [7:4] tx same
	input wire logic [7:0] serial_audio_port,
	input wire logic [7:0] serial_audio_port_second,
	// Host interface: tx, underrun, rx not empty, rx full, overrun, bus error
	input wire logic [5:0] host_serial_interface,
	input wire logic [5:0] host_serial_interface_second,
	// Vector to the core
	output logic vector_pending,
	output logic [vector_map_pkg::ADDR_W-1:0] vector_addr,
	output logic [1:0] vector_level
);

	// ------------------------------------------------------------
	// Types and signals
	// ------------------------------------------------------------
	typedef struct packed {
		logic pending;
		logic [vector_map_pkg::ADDR_W-1:0] addr;
		logic [1:0] level;
	} state_t;

	state_t state;
	state_t next_state;
	logic stall_sel;
	logic [7:0] dma_sel;
	logic [7:0] audio_sel;
	logic [5:0] host_sel;
	logic [vector_map_pkg::SLOTS-1:0] fixed_slot;
	logic [vector_map_pkg::SLOTS-1:0] reserved_slot;
	logic [vector_map_pkg::ADDR_W-1:0] slot_offset;
	logic [vector_map_pkg::ADDR_W:0] addr_sum;
	vector_arb_if arb_bus ();

	// ------------------------------------------------------------
	// Per-core source selection
	// ------------------------------------------------------------

	assign stall_sel = core_id ? core_interface_monitor_second : core_interface_monitor;
	assign dma_sel = core_id ? dma_second : dma_first;
	assign audio_sel = core_id ? serial_audio_port_second : serial_audio_port;
	assign host_sel = core_id ? host_serial_interface_second : host_serial_interface;

	// ------------------------------------------------------------
	// Slot classes
	// ------------------------------------------------------------

	always_comb begin
		fixed_slot = '0;
		fixed_slot[vector_map_pkg::slot_of(vector_map_pkg::OFF_RESET)] = 1'b1;
		fixed_slot[vector_map_pkg::slot_of(vector_map_pkg::OFF_STACK_ERR)] = 1'b1;
		fixed_slot[vector_map_pkg::slot_of(vector_map_pkg::OFF_ILLEGAL)] = 1'b1;
		fixed_slot[vector_map_pkg::slot_of(vector_map_pkg::OFF_DEBUG)] = 1'b1;
		fixed_slot[vector_map_pkg::slot_of(vector_map_pkg::OFF_TRAP)] = 1'b1;
		fixed_slot[vector_map_pkg::slot_of(vector_map_pkg::OFF_EXT_NMI)] = 1'b1;
		fixed_slot[vector_map_pkg::slot_of(vector_map_pkg::OFF_STALL)] = 1'b1;
		fixed_slot[vector_map_pkg::slot_of(vector_map_pkg::OFF_ICC_NMI)] = 1'b1;
	end

	always_comb begin
		reserved_slot = '0;
		reserved_slot[vector_map_pkg::slot_of(vector_map_pkg::OFF_RSV_0C)] = 1'b1;
		reserved_slot[vector_map_pkg::slot_of(vector_map_pkg::OFF_RSV_2E)] = 1'b1;
		reserved_slot[vector_map_pkg::slot_of(vector_map_pkg::OFF_RSV_46)] = 1'b1;
		// Tail of the map from the slot at offset 4E up
		for (int i = 0; i < vector_map_pkg::SLOTS; i++) begin
			if (i >= vector_map_pkg::slot_of(vector_map_pkg::OFF_RSV_4E)) begin
				reserved_slot[i] = 1'b1;
			end
		end
	end

	// ------------------------------------------------------------
	// Slot map
	// ------------------------------------------------------------

	// Place each source in its slot; slots left zero are reserved
	always_comb begin
		arb_bus.req = '0;
		arb_bus.req[vector_map_pkg::slot_of(vector_map_pkg::OFF_RESET)] = reset_req;
		arb_bus.req[vector_map_pkg::slot_of(vector_map_pkg::OFF_STACK_ERR)] = stack_error;
		arb_bus.req[vector_map_pkg::slot_of(vector_map_pkg::OFF_ILLEGAL)] = illegal_instr;
		arb_bus.req[vector_map_pkg::slot_of(vector_map_pkg::OFF_DEBUG)] = debug_req;
		arb_bus.req[vector_map_pkg::slot_of(vector_map_pkg::OFF_TRAP)] = trap_req;
		arb_bus.req[vector_map_pkg::slot_of(vector_map_pkg::OFF_EXT_NMI)] = ext_nmi;
		arb_bus.req[vector_map_pkg::slot_of(vector_map_pkg::OFF_STALL)] = stall_sel;
		arb_bus.req[vector_map_pkg::slot_of(vector_map_pkg::OFF_EXT_REQ) +: 4] =
			{ext_request_d, ext_request_c, ext_request_b, ext_request_a};
		arb_bus.req[vector_map_pkg::slot_of(vector_map_pkg::OFF_DMA) +: 8] = dma_sel;
		arb_bus.req[vector_map_pkg::slot_of(vector_map_pkg::OFF_ICC_NMI)] = icc_nmi;
		arb_bus.req[vector_map_pkg::slot_of(vector_map_pkg::OFF_ICC_REQ)] = icc_request;
		arb_bus.req[vector_map_pkg::slot_of(vector_map_pkg::OFF_ICC_ACK)] = icc_ack;
		arb_bus.req[vector_map_pkg::slot_of(vector_map_pkg::OFF_AUDIO_RX) +: 4] = audio_sel[3:0];
		arb_bus.req[vector_map_pkg::slot_of(vector_map_pkg::OFF_AUDIO_TX) +: 4] = audio_sel[7:4];
		arb_bus.req[vector_map_pkg::slot_of(vector_map_pkg::OFF_HOST_TX)] = host_sel[0];
		arb_bus.req[vector_map_pkg::slot_of(vector_map_pkg::OFF_HOST_UNDERRUN)] = host_sel[1];
		arb_bus.req[vector_map_pkg::slot_of(vector_map_pkg::OFF_HOST_RX_NE)] = host_sel[2];
		arb_bus.req[vector_map_pkg::slot_of(vector_map_pkg::OFF_HOST_RX_FULL)] = host_sel[3];
		arb_bus.req[vector_map_pkg::slot_of(vector_map_pkg::OFF_HOST_OVERRUN)] = host_sel[4];
		arb_bus.req[vector_map_pkg::slot_of(vector_map_pkg::OFF_HOST_BUS_ERR)] = host_sel[5];
		for (int i = 0; i < vector_map_pkg::SLOTS; i++) begin
			if (reserved_slot[i]) begin
				arb_bus.req[i] = 1'b0;
			end
		end
	end

	// ------------------------------------------------------------
	// Levels
	// ------------------------------------------------------------

	// fixed level 3, otherwise programmed value capped at 2
	always_comb begin
		logic [1:0] p;
		p = 2'h0;
		for (int i = 0; i < vector_map_pkg::SLOTS; i++) begin
			p = slot_levels[2*i +: 2];
			if (fixed_slot[i]) begin
				arb_bus.lvl[2*i +: 2] = vector_map_pkg::LEVEL_NMI;
			end else if (p > vector_map_pkg::LEVEL_MASK_MAX) begin
				arb_bus.lvl[2*i +: 2] = vector_map_pkg::LEVEL_MASK_MAX;
			end else begin
				arb_bus.lvl[2*i +: 2] = p;
			end
		end
	end

	// ------------------------------------------------------------
	// Arbitration
	// ------------------------------------------------------------

	// Core mask level for maskable slots
	assign arb_bus.mask = interrupt_priority_level;

	// Arbiter picks the winning slot
	vector_arbiter u_arbiter (
		.bus(arb_bus.arb)
	);

	// ------------------------------------------------------------
	// Vector register
	// ------------------------------------------------------------

	// word offset is twice the slot index
	assign slot_offset = {{(vector_map_pkg::ADDR_W-7){1'b0}}, arb_bus.slot, 1'b0};

	// Base plus offset; a carry past the top wraps round
	assign addr_sum = {1'b0, vector_base} + {1'b0, slot_offset};

	// base plus twice the slot index
	always_comb begin
		next_state.pending = arb_bus.found;
		next_state.addr = addr_sum[vector_map_pkg::ADDR_W-1:0];
		next_state.level = arb_bus.level;
	end

	// Register the winner every cycle
	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			state <= '{1'b0, vector_map_pkg::VECTOR_RESET, vector_map_pkg::LEVEL_RESET};
		end else begin
			state <= next_state;
		end
	end

	assign vector_pending = state.pending;
	assign vector_addr = state.addr;
	assign vector_level = state.level;

endmodule : int_vector_map

//--- verilog/vector_map_pkg.sv
// Constants for the per-core interrupt vector map
package vector_map_pkg;

	// ------------------------------------------------------------
	// Widths
	// ------------------------------------------------------------
	localparam int SLOTS = 42;
	localparam int ADDR_W = 24;
	localparam logic [1:0] LEVEL_NMI = 2'h3;
	localparam logic [1:0] LEVEL_MASK_MAX = 2'h2;
	localparam logic [1:0] LEVEL_RESET = 2'h0;
	localparam logic [ADDR_W-1:0] VECTOR_RESET = 24'h000000;

	// ------------------------------------------------------------
	// Slot offsets, in words from the vector base
	// ------------------------------------------------------------
	localparam logic [7:0] OFF_RESET = 8'h00;
	localparam logic [7:0] OFF_STACK_ERR = 8'h02;
	localparam logic [7:0] OFF_ILLEGAL = 8'h04;
	localparam logic [7:0] OFF_DEBUG = 8'h06;
	localparam logic [7:0] OFF_TRAP = 8'h08;
	localparam logic [7:0] OFF_EXT_NMI = 8'h0A;
	localparam logic [7:0] OFF_RSV_0C = 8'h0C;
	localparam logic [7:0] OFF_STALL = 8'h0E;
	localparam logic [7:0] OFF_EXT_REQ = 8'h10;
	localparam logic [7:0] OFF_DMA = 8'h18;
	localparam logic [7:0] OFF_ICC_NMI = 8'h28;
	localparam logic [7:0] OFF_ICC_REQ = 8'h2A;
	localparam logic [7:0] OFF_ICC_ACK = 8'h2C;
	localparam logic [7:0] OFF_RSV_2E = 8'h2E;
	localparam logic [7:0] OFF_AUDIO_RX = 8'h30;
	localparam logic [7:0] OFF_AUDIO_TX = 8'h38;
	localparam logic [7:0] OFF_HOST_TX = 8'h40;
	localparam logic [7:0] OFF_HOST_UNDERRUN = 8'h42;
	localparam logic [7:0] OFF_HOST_RX_NE = 8'h44;
	localparam logic [7:0] OFF_RSV_46 = 8'h46;
	localparam logic [7:0] OFF_HOST_RX_FULL = 8'h48;
	localparam logic [7:0] OFF_HOST_OVERRUN = 8'h4A;
	localparam logic [7:0] OFF_HOST_BUS_ERR = 8'h4C;
	localparam logic [7:0] OFF_RSV_4E = 8'h4E;

	// Slot index of a word offset
	function automatic int slot_of(input logic [7:0] off);
		return int'(off >> 1);
	endfunction : slot_of

endpackage : vector_map_pkg

//--- verilog/vector_arb_if.sv
// Request set and arbitration result passed between map and arbiter
interface vector_arb_if;
	logic [vector_map_pkg::SLOTS-1:0] req;
	logic [2*vector_map_pkg::SLOTS-1:0] lvl;
	logic [1:0] mask;
	logic found;
	logic [5:0] slot;
	logic [1:0] level;

	modport src (
		output req,
		output lvl,
		output mask,
		input found,
		input slot,
		input level
	);

	modport arb (
		input req,
		input lvl,
		input mask,
		output found,
		output slot,
		output level
	);
endinterface : vector_arb_if

//--- verilog/vector_arbiter.sv
// Picks the highest-level accepted slot, lowest offset on a tie
module vector_arbiter (
	// Request set and result
	vector_arb_if.arb bus
);

	// ------------------------------------------------------------
	// Selection
	// ------------------------------------------------------------

	// Level 3 always passes, others must reach the core mask level
	always_comb begin
		logic [1:0] l;
		logic hit;
		l = 2'h0;
		hit = 1'b0;
		bus.found = 1'b0;
		bus.slot = 6'h00;
		bus.level = 2'h0;
		for (int i = 0; i < vector_map_pkg::SLOTS; i++) begin
			l = bus.lvl[2*i +: 2];
			hit = bus.req[i] && (l == vector_map_pkg::LEVEL_NMI || l >= bus.mask);
			if (hit && (!bus.found || l > bus.level)) begin
				bus.found = 1'b1;
				bus.slot = 6'(i);
				bus.level = l;
			end
		end
	end

endmodule : vector_arbiter

//--- bench/vector_map_assertions.sv
// Checker for the vector map outputs
module vector_map_assertions (
	// Clock, reset and setup
	input wire logic sys_clk,
	input wire logic rstn,
	input wire logic core_id,
	input wire logic [23:0] vector_base,
	input wire logic [1:0] interrupt_priority_level,
	// Level 3 sources
	input wire logic reset_req,
	input wire logic stack_error,
	input wire logic illegal_instr,
	input wire logic debug_req,
	input wire logic trap_req,
	input wire logic ext_nmi,
	input wire logic core_interface_monitor,
	input wire logic core_interface_monitor_second,
	input wire logic icc_nmi,
	// Vector out
	input wire logic vector_pending,
	input wire logic [23:0] vector_addr,
	input wire logic [1:0] vector_level
);
	timeunit 1ns;
	timeprecision 1ns;
	logic live, stall_q, nmi_q;
	logic [1:0] mask_q;
	logic [5:0] exc_q;
	logic [23:0] base_q, off;
	// Causes as seen at the previous edge
	always_ff @(posedge sys_clk) begin
		live <= rstn;
		base_q <= vector_base;
		mask_q <= interrupt_priority_level;
		exc_q <= {ext_nmi, trap_req, debug_req, illegal_instr, stack_error, reset_req};
		stall_q <= core_id ? core_interface_monitor_second : core_interface_monitor;
		nmi_q <= icc_nmi;
	end
	// Offset from the base in force
	assign off = vector_addr - base_q;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rstn);
	even_offset_a: assert property (live && vector_pending |-> !off[0])
		else $error("Odd vector offset");
	reset_slot_a: assert property (live && exc_q[0] |-> off == 24'h0 && vector_level == 2'h3)
		else $error("Reset not at offset zero");
	exc_order_a: assert property (live && exc_q != 6'h00 |-> off < 24'h0C
		&& exc_q[off[3:1]] && (exc_q & ~(6'h3F << off[3:1])) == 6'h00)
		else $error("Wrong exception slot");
	stall_slot_a: assert property (live && exc_q == 6'h00 && stall_q |-> off == 24'h0E)
		else $error("Stall not at its slot");
	icc_nmi_a: assert property (live && exc_q == 6'h00 && !stall_q && nmi_q |->
		off == 24'h28 && vector_level == 2'h3)
		else $error("Inter-core nmi misplaced");
	fixed_level_a: assert property (live && vector_pending &&
		(off < 24'h10 || off == 24'h28) |-> vector_level == 2'h3)
		else $error("Fixed slot not at level 3");
	mask_level_a: assert property (live && vector_pending && off >= 24'h10 &&
		off != 24'h28 |-> vector_level <= 2'h2 && vector_level >= mask_q)
		else $error("Maskable level out of range");
	reserved_a: assert property (live && vector_pending |->
		!(off inside {24'h0C, 24'h2E, 24'h46}) && off < 24'h4E)
		else $error("Reserved slot selected");
	cover property (live && stall_q && exc_q == 6'h00);
	cover property (vector_pending && vector_level < 2'h3);
	cover property (live && !vector_pending);
endmodule : vector_map_assertions

//--- bench/core_fetch_model.sv
// Core side model that takes every vector offered
module core_fetch_model (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rstn,
	// Vector from the map
	input wire logic vector_pending,
	// Fetch count
	output int fetches
);
	timeunit 1ns;
	timeprecision 1ns;
	// Count the edges with a vector on offer
	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			fetches <= 0;
		end else if (vector_pending) begin
			fetches <= fetches + 1;
		end
	end
endmodule : core_fetch_model

//--- bench/tb.sv
// Self-checking bench for the interrupt vector map
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic sys_clk, rstn, core_id, reset_req, stack_error, illegal_instr, debug_req, trap_req;
	logic ext_nmi, ext_request_a, ext_request_b, ext_request_c, ext_request_d;
	logic core_interface_monitor, core_interface_monitor_second, icc_nmi, icc_request, icc_ack;
	logic vector_pending;
	logic [1:0] interrupt_priority_level, vector_level;
	logic [7:0] dma_first, dma_second, serial_audio_port, serial_audio_port_second;
	logic [5:0] host_serial_interface, host_serial_interface_second;
	logic [23:0] vector_base, vector_addr;
	logic [83:0] slot_levels;
	logic [41:0] r;
	int mismatches, checks_done, fetches, npend;
	int_vector_map dut (.*);
	core_fetch_model fm (.sys_clk, .rstn, .vector_pending, .fetches);
	// Clock
	initial begin
		sys_clk = 1'b0;
		forever #25 sys_clk = ~sys_clk;
	end
	// Compare and count
	task automatic check(input string what, input logic [26:0] seen, input logic [26:0] exp);
		checks_done++;
		if (seen !== exp) begin
			mismatches++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	// Winner: highest level, lowest offset
	function automatic logic [26:0] expect_vec(input logic [41:0] q);
		logic [1:0] l, bl;
		logic hit;
		logic [7:0] bo;
		hit = 1'b0;
		bl = 2'h0;
		bo = 8'h00;
		for (int i = 0; i < 42; i++) begin
			l = slot_levels[2*i+:2];
			if (l == 2'h3) l = 2'h2;
			if (i < 8 || i == 20) l = 2'h3;
			if (q[i] && !(i inside {6, 23, 35, 39, 40, 41}) && l >= interrupt_priority_level
				&& (!hit || l > bl)) begin
				hit = 1'b1;
				bl = l;
				bo = 8'(2 * i);
			end
		end
		return {hit, vector_base + {16'h0000, bo}, bl};
	endfunction : expect_vec
	// Slot bits onto ports; n goes to the other core's instances
	task automatic apply(input logic [41:0] q, input logic [22:0] n, input logic c);
		logic [22:0] own;
		own = {q[7], q[19:12], q[31:24], q[38:36], q[34:32]};
		core_id = c;
		{ext_nmi, trap_req, debug_req, illegal_instr, stack_error, reset_req} = q[5:0];
		{ext_request_d, ext_request_c, ext_request_b, ext_request_a} = q[11:8];
		{icc_ack, icc_request, icc_nmi} = q[22:20];
		{core_interface_monitor, dma_first, serial_audio_port, host_serial_interface} = c ? n : own;
		{core_interface_monitor_second, dma_second, serial_audio_port_second,
			host_serial_interface_second} = c ? own : n;
	endtask : apply
	// One edge per step
	task automatic step(input logic [41:0] q, input logic c);
		logic [26:0] e;
		apply(q, 23'($urandom), c);
		e = expect_vec(q);
		npend += int'(e[26]);
		@(posedge sys_clk);
		#5;
		check("vector", {vector_pending, vector_addr, vector_level}, e);
	endtask : step
	task automatic test_done();
		$display("Checks %0d mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : test_done
	// Hang guard
	initial begin
		#1000000;
		mismatches++;
		test_done();
	end
	// Main sequence
	initial begin
		mismatches = 0;
		checks_done = 0;
		npend = 0;
		void'($urandom(32'h9CF0564E));
		rstn = 1'b0;
		vector_base = 24'h00ABCD;
		interrupt_priority_level = 2'h0;
		slot_levels = '0;
		apply(~42'h0, 23'h0, 1'b0);
		repeat (3) @(posedge sys_clk);
		#5;
		check("reset", {vector_pending, vector_addr, vector_level}, 27'h0);
		rstn = 1'b1;
		for (int c = 0; c < 2; c++) begin
			for (int i = 0; i < 42; i++) begin
				slot_levels = 84'({$urandom, $urandom, $urandom});
				vector_base = 24'($urandom);
				step(42'h1 << i, c[0]);
			end
		end
		repeat (400) begin
			slot_levels = 84'({$urandom, $urandom, $urandom});
			interrupt_priority_level = 2'($urandom);
			r = 42'({$urandom, $urandom}) & 42'({$urandom, $urandom});
			step(r & (($urandom % 2) ? ~42'h1000FF : ~42'h0), 1'($urandom));
		end
		slot_levels = '1;
		interrupt_priority_level = 2'h3;
		step(~42'h1000FF, 1'b1);
		step(42'h0, 1'b0);
		check("fetches", 27'(fetches), 27'(npend));
		// Mid-run reset clears the outputs
		apply(~42'h0, 23'h0, 1'b0);
		rstn = 1'b0;
		@(posedge sys_clk);
		#5;
		check("reset", {vector_pending, vector_addr, vector_level}, 27'h0);
		// Release again: first edge already registers live inputs
		rstn = 1'b1;
		step(42'h1 << 20, 1'b1);
		test_done();
	end
endmodule : tb
bind int_vector_map vector_map_assertions chk (.*);
